/* mai_pkg.sv */
// package of constants for the motor axis interface
package mai_pkg;
  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] MAI_OFF_CTRL = 8'h00;
  localparam logic [7:0] MAI_OFF_STATUS = 8'h04;
  localparam logic [7:0] MAI_OFF_POSITION = 8'h08;
  localparam logic [7:0] MAI_OFF_LATCH = 8'h0C;
  localparam logic [7:0] MAI_OFF_COMPARE = 8'h10;
  localparam logic [7:0] MAI_OFF_DAC = 8'h14;
  localparam logic [7:0] MAI_OFF_STEP_PERIOD = 8'h18;
  localparam logic [7:0] MAI_OFF_STEP_CMD = 8'h1C;
  localparam logic [7:0] MAI_OFF_CURRENT = 8'h20;
  localparam logic [7:0] MAI_OFF_WDOG = 8'h24;
  localparam logic [7:0] MAI_OFF_MICRO = 8'h28;
  // ****************************************
  // control register fields
  // ****************************************
  localparam int MAI_CTRL_STEPPER = 0;
  localparam int MAI_CTRL_PULSE_DIR = 1;
  localparam int MAI_CTRL_AMP_ON = 2;
  localparam int MAI_CTRL_IDLE_RED = 3;
  localparam int MAI_CTRL_CMP_EN = 4;
  localparam int MAI_CTRL_INDEX_ZERO = 5;
  localparam int MAI_CTRL_LATCH_ARM = 6;
  localparam int MAI_CTRL_LSRC_LO = 7;
  localparam int MAI_CTRL_RES_LO = 9;
  localparam logic [10:0] MAI_CTRL_RESET = 11'h000;
  // ****************************************
  // status register fields (sticky ones cleared by writing one, except tripped, which only reset clears)
  // ****************************************
  localparam int MAI_ST_TRIPPED = 0;
  localparam int MAI_ST_MOVING = 1;
  localparam int MAI_ST_LATCHED = 2;
  localparam int MAI_ST_CMP_HIT = 3;
  localparam int MAI_ST_FAULT_LO = 4;
  localparam int MAI_ST_STRAP = 8;
  localparam int MAI_ST_AMP_EN = 9;
  // ****************************************
  // current register fields
  // ****************************************
  localparam int MAI_CUR_CODE_LO = 0;
  localparam int MAI_CUR_STEP_GAIN_LO = 8;
  localparam int MAI_CUR_SERVO_GAIN_LO = 10;
  localparam logic [11:0] MAI_CUR_RESET = 12'h000;
  localparam logic [1:0] MAI_SERVO_GAIN_MAX = 2'h2;
  // ****************************************
  // step resolution codes and microsteps per step
  // ****************************************
  localparam logic [1:0] MAI_RES_FULL = 2'h0;
  localparam logic [1:0] MAI_RES_HALF = 2'h1;
  localparam logic [1:0] MAI_RES_QUARTER = 2'h2;
  localparam logic [1:0] MAI_RES_SIXTEENTH = 2'h3;
  localparam logic [9:0] MAI_USTEP_FULL = 10'h100;
  localparam logic [9:0] MAI_USTEP_HALF = 10'h080;
  localparam logic [9:0] MAI_USTEP_QUARTER = 10'h040;
  localparam logic [9:0] MAI_USTEP_SIXTEENTH = 10'h010;
  // ****************************************
  // timing
  // ****************************************
  localparam int MAI_CLK_HZ = 50000000;
  localparam int MAI_STEP_MAX_HZ = 3000000;
  localparam int MAI_PWM_HZ = 33000;
  localparam int MAI_STEP_MIN_CYC = (MAI_CLK_HZ + MAI_STEP_MAX_HZ - 1) / MAI_STEP_MAX_HZ;
  localparam int MAI_PWM_CYC = MAI_CLK_HZ / MAI_PWM_HZ;
  localparam int MAI_STEP_HIGH_CYC = MAI_STEP_MIN_CYC / 2;
  localparam int MAI_WDOG_TIMEOUT_MS = 100;
  localparam int MAI_WDOG_CYC = (MAI_CLK_HZ / 1000) * MAI_WDOG_TIMEOUT_MS;
  localparam logic [15:0] MAI_WDOG_KEY = 16'hA5C3;
  // boot lasts until the strap level has crossed both synchroniser flops
  localparam logic [1:0] MAI_BOOT_CYC = 2'h3;
endpackage

/* mai_axis.sv */
// single-axis motor interface: encoder, latch, compare, step, servo word, watchdog
//
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module mai_axis
  import mai_pkg::*;
#(
  parameter int WDOG_CYC = MAI_WDOG_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // encoder and latch pins
  input wire logic encoder_phase_a,
  input wire logic encoder_phase_b,
  input wire logic encoder_index,
  input wire logic [1:0] latch_in,
  // straps and amplifier fault pins
  input wire logic motor_off_strap,
  input wire logic [3:0] amp_fault_in,
  // motor outputs
  output logic step_out,
  output logic dir_out,
  output logic [15:0] dac_word,
  output logic pwm_out,
  output logic compare_out,
  output logic [6:0] phase_current,
  output logic [1:0] step_gain,
  output logic [1:0] servo_gain,
  output logic [1:0] step_resolution,
  output logic [9:0] micro_position,
  // supervision outputs
  output logic amplifier_enable_out,
  output logic error_led
);
  // ****************************************
  // input synchronisers
  // ****************************************
  logic [9:0] sync1;
  logic [9:0] sync2;
  logic [9:0] pins;
  assign pins = {motor_off_strap, amp_fault_in, latch_in, encoder_index, encoder_phase_b, encoder_phase_a};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 10'h000;
      sync2 <= 10'h000;
    end else begin
      sync1 <= pins;
      sync2 <= sync1;
    end
  end
  logic [9:0] prev;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev <= 10'h000;
    end else begin
      prev <= sync2;
    end
  end
  wire logic ph_a = sync2[0];
  wire logic ph_b = sync2[1];
  wire logic [2:0] trig_rise = sync2[4:2] & ~prev[4:2];
  wire logic [3:0] faults = sync2[8:5];
  // ****************************************
  // registers
  // ****************************************
  logic [10:0] ctrl;
  logic [31:0] position;
  logic [31:0] latch_pos;
  logic [31:0] compare_val;
  logic [15:0] dac_reg;
  logic [15:0] step_period;
  logic [15:0] steps_left;
  logic step_dir;
  logic [11:0] current_reg;
  logic latched;
  logic cmp_hit;
  logic [3:0] fault_sticky;
  logic tripped;
  logic strap_seen;
  logic [31:0] wdog_cnt;
  // ****************************************
  // apb decode
  // ****************************************
  wire logic acc = psel & penable & ~pready;
  wire logic wr = acc & pwrite;
  wire logic hit_ctrl = paddr == MAI_OFF_CTRL;
  wire logic hit_status = paddr == MAI_OFF_STATUS;
  wire logic hit_pos = paddr == MAI_OFF_POSITION;
  wire logic hit_latch = paddr == MAI_OFF_LATCH;
  wire logic hit_cmp = paddr == MAI_OFF_COMPARE;
  wire logic hit_dac = paddr == MAI_OFF_DAC;
  wire logic hit_per = paddr == MAI_OFF_STEP_PERIOD;
  wire logic hit_cmd = paddr == MAI_OFF_STEP_CMD;
  wire logic hit_cur = paddr == MAI_OFF_CURRENT;
  wire logic hit_wdog = paddr == MAI_OFF_WDOG;
  wire logic hit_micro = paddr == MAI_OFF_MICRO;
  wire logic mapped = hit_ctrl | hit_status | hit_pos | hit_latch | hit_cmp | hit_dac | hit_per | hit_cmd
    | hit_cur | hit_wdog | hit_micro;
  wire logic moving = steps_left != 16'h0000;
  wire logic [9:0] status = {amplifier_enable_out, strap_seen, fault_sticky, cmp_hit, latched, moving, tripped};
  wire logic [31:0] rd_mux =
    hit_ctrl ? {21'h000000, ctrl} :
    hit_status ? {22'h000000, status} :
    hit_pos ? position :
    hit_latch ? latch_pos :
    hit_cmp ? compare_val :
    hit_dac ? {16'h0000, dac_reg} :
    hit_per ? {16'h0000, step_period} :
    hit_cmd ? {15'h0000, step_dir, steps_left} :
    hit_cur ? {20'h00000, current_reg} :
    hit_micro ? {22'h000000, micro_position} : 32'h00000000;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= acc;
      prdata <= (acc & ~pwrite) ? rd_mux : 32'h00000000;
      pslverr <= acc & ~mapped;
    end
  end
  // write strobe is registered with pready so the write lands on the completing edge
  logic wr_q;
  logic [7:0] addr_q;
  logic [31:0] wdata_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_q <= 1'b0;
      addr_q <= 8'h00;
      wdata_q <= 32'h00000000;
    end else begin
      wr_q <= wr;
      addr_q <= paddr;
      wdata_q <= pwdata;
    end
  end
  wire logic w_ctrl = wr_q & (addr_q == MAI_OFF_CTRL);
  wire logic w_status = wr_q & (addr_q == MAI_OFF_STATUS);
  wire logic w_pos = wr_q & (addr_q == MAI_OFF_POSITION);
  wire logic w_cmp = wr_q & (addr_q == MAI_OFF_COMPARE);
  wire logic w_dac = wr_q & (addr_q == MAI_OFF_DAC);
  wire logic w_per = wr_q & (addr_q == MAI_OFF_STEP_PERIOD);
  wire logic w_cmd = wr_q & (addr_q == MAI_OFF_STEP_CMD);
  wire logic w_cur = wr_q & (addr_q == MAI_OFF_CURRENT);
  wire logic kick = wr_q & (addr_q == MAI_OFF_WDOG) & (wdata_q[15:0] == MAI_WDOG_KEY);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= MAI_CTRL_RESET;
      compare_val <= 32'h00000000;
      dac_reg <= 16'h0000;
      step_period <= 16'h0000;
      current_reg <= MAI_CUR_RESET;
    end else begin
      if (w_ctrl) ctrl <= wdata_q[10:0];
      if (w_cmp) compare_val <= wdata_q;
      if (w_dac) dac_reg <= wdata_q[15:0];
      if (w_per) step_period <= wdata_q[15:0];
      if (w_cur) current_reg <= wdata_q[11:0];
    end
  end
  // ****************************************
  // encoder decoding
  // ****************************************
  // gray index of {b,a}: 00,01,11,10 walks forward when a leads b
  wire logic [1:0] cur_q = {ph_b, ph_a ^ ph_b};
  wire logic [1:0] old_q = {prev[1], prev[0] ^ prev[1]};
  wire logic [1:0] qdiff = cur_q - old_q;
  wire logic q_up = qdiff == 2'h1;
  wire logic q_dn = qdiff == 2'h3;
  wire logic pd_edge = ph_a & ~prev[0];
  wire logic cnt_up = ctrl[MAI_CTRL_PULSE_DIR] ? (pd_edge & ~ph_b) : q_up;
  wire logic cnt_dn = ctrl[MAI_CTRL_PULSE_DIR] ? (pd_edge & ph_b) : q_dn;
  wire logic index_sync = trig_rise[0] & ctrl[MAI_CTRL_INDEX_ZERO];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      position <= 32'h00000000;
    end else if (w_pos) begin
      position <= wdata_q;
    end else if (index_sync) begin
      position <= 32'h00000000;
    end else if (cnt_up) begin
      position <= position + 32'h00000001;
    end else if (cnt_dn) begin
      position <= position - 32'h00000001;
    end
  end
  // ****************************************
  // position latch and compare
  // ****************************************
  // source code 3 selects no trigger
  wire logic [3:0] trig_set = {1'b0, trig_rise};
  wire logic trig = trig_set[ctrl[MAI_CTRL_LSRC_LO +: 2]];
  wire logic latch_now = trig & ctrl[MAI_CTRL_LATCH_ARM] & ~latched;
  wire logic cmp_match = ctrl[MAI_CTRL_CMP_EN] & (position == compare_val);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_pos <= 32'h00000000;
      latched <= 1'b0;
      cmp_hit <= 1'b0;
      compare_out <= 1'b0;
    end else begin
      if (latch_now) latch_pos <= position;
      latched <= latch_now | (latched & ~(w_status & wdata_q[MAI_ST_LATCHED]));
      cmp_hit <= cmp_match | (cmp_hit & ~(w_status & wdata_q[MAI_ST_CMP_HIT]));
      compare_out <= cmp_match;
    end
  end
  // ****************************************
  // step generator and microstep sequencer
  // ****************************************
  wire logic stepper = ctrl[MAI_CTRL_STEPPER];
  wire logic [15:0] min_per = 16'(MAI_STEP_MIN_CYC);
  wire logic [15:0] eff_per = (step_period < min_per) ? min_per : step_period;
  wire logic [1:0] res = ctrl[MAI_CTRL_RES_LO +: 2];
  wire logic [9:0] ustep_inc =
    (res == MAI_RES_FULL) ? MAI_USTEP_FULL :
    (res == MAI_RES_HALF) ? MAI_USTEP_HALF :
    (res == MAI_RES_QUARTER) ? MAI_USTEP_QUARTER : MAI_USTEP_SIXTEENTH;
  logic [15:0] per_cnt;
  wire logic step_fire = stepper & moving & amplifier_enable_out & (per_cnt == 16'h0000);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      steps_left <= 16'h0000;
      step_dir <= 1'b0;
      per_cnt <= 16'h0000;
      step_out <= 1'b0;
      dir_out <= 1'b0;
      micro_position <= 10'h000;
    end else begin
      if (w_cmd) begin
        steps_left <= wdata_q[15:0];
        step_dir <= wdata_q[16];
      end else if (step_fire) begin
        steps_left <= steps_left - 16'h0001;
      end
      if (step_fire) begin
        per_cnt <= eff_per - 16'h0001;
      end else if (per_cnt != 16'h0000) begin
        per_cnt <= per_cnt - 16'h0001;
      end
      if (step_fire) begin
        step_out <= 1'b1;
      end else if (per_cnt == eff_per - 16'(MAI_STEP_HIGH_CYC)) begin
        step_out <= 1'b0;
      end
      dir_out <= step_dir;
      if (step_fire) begin
        micro_position <= step_dir ? micro_position - ustep_inc : micro_position + ustep_inc;
      end
    end
  end
  // ****************************************
  // current settings and servo command
  // ****************************************
  wire logic [6:0] cur_code = current_reg[MAI_CUR_CODE_LO +: 7];
  wire logic idle_cut = ctrl[MAI_CTRL_IDLE_RED] & ~moving;
  wire logic [1:0] sg_req = current_reg[MAI_CUR_SERVO_GAIN_LO +: 2];
  logic [10:0] pwm_cnt;
  wire logic [15:0] dac_mag = dac_reg[15] ? ~dac_reg : dac_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_current <= 7'h00;
      step_gain <= 2'h0;
      servo_gain <= 2'h0;
      step_resolution <= MAI_RES_FULL;
      dac_word <= 16'h0000;
      pwm_cnt <= 11'h000;
      pwm_out <= 1'b0;
    end else begin
      phase_current <= idle_cut ? {2'h0, cur_code[6:2]} : cur_code;
      step_gain <= current_reg[MAI_CUR_STEP_GAIN_LO +: 2];
      servo_gain <= (sg_req > MAI_SERVO_GAIN_MAX) ? MAI_SERVO_GAIN_MAX : sg_req;
      step_resolution <= res;
      dac_word <= (stepper | ~amplifier_enable_out) ? 16'h0000 : dac_reg;
      pwm_cnt <= (pwm_cnt == 11'(MAI_PWM_CYC - 1)) ? 11'h000 : pwm_cnt + 11'h001;
      pwm_out <= ~stepper & amplifier_enable_out
        & ({pwm_cnt, 4'h0} < 15'(({16'h0000, dac_mag[14:0]} * MAI_PWM_CYC) >> 11));
    end
  end
  // ****************************************
  // faults, watchdog and amplifier enable
  // ****************************************
  logic [1:0] boot_cnt;
  wire logic boot = boot_cnt != 2'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_sticky <= 4'h0;
      boot_cnt <= MAI_BOOT_CYC;
      strap_seen <= 1'b0;
    end else begin
      fault_sticky <= faults | (fault_sticky & ~({4{w_status}} & wdata_q[MAI_ST_FAULT_LO +: 4]));
      if (boot) boot_cnt <= boot_cnt - 2'h1;
      // synchronisers hold zero in reset, so capture only once the pin has arrived
      if (boot_cnt == 2'h1) strap_seen <= sync2[9];
    end
  end
  wire logic wdog_expired = (wdog_cnt == 32'h00000000) & ~boot;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdog_cnt <= 32'(WDOG_CYC);
      tripped <= 1'b0;
      amplifier_enable_out <= 1'b0;
      error_led <= 1'b1;
    end else begin
      if (kick) begin
        wdog_cnt <= 32'(WDOG_CYC);
      end else if (wdog_cnt != 32'h00000000) begin
        wdog_cnt <= wdog_cnt - 32'h00000001;
      end
      if (wdog_expired) tripped <= 1'b1;
      amplifier_enable_out <= ~tripped & ~wdog_expired & ~strap_seen & ~boot & ctrl[MAI_CTRL_AMP_ON]
        & (fault_sticky == 4'h0) & (faults == 4'h0);
      error_led <= tripped | wdog_expired;
    end
  end
endmodule

/* mai_axis_sva.sv */
// checker of the motor axis interface port behaviour
`timescale 1ns/1ps
module mai_axis_sva
  import mai_pkg::*;
#(
  parameter int WDOG_CYC = MAI_WDOG_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // motor side
  input wire logic [3:0] amp_fault_in,
  input wire logic step_out,
  input wire logic [15:0] dac_word,
  input wire logic amplifier_enable_out,
  input wire logic error_led
);
  // ****
  // helper logic
  // ****
  logic [1:0] up_cnt;
  logic [4:0] gap;
  logic step_q;
  wire step_rise = step_out && !step_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_cnt <= 2'h0;
      gap <= 5'h1F;
      step_q <= 1'b0;
    end else begin
      up_cnt <= (up_cnt == 2'h3) ? up_cnt : up_cnt + 2'h1;
      gap <= step_rise ? 5'h00 : ((gap == 5'h1F) ? gap : gap + 5'h01);
      step_q <= step_out;
    end
  end
  // ****
  // properties
  // ****
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence seq_access;
    psel && penable && !pready;
  endsequence
  sequence seq_pulse;
    step_out [*8] ##1 !step_out;
  endsequence
  AST_APB_WAIT: assert property (seq_access |=> pready)
    else $error("pready not given after one wait state");
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_PREADY_ACCESS: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  AST_SLVERR_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_BOOT_LOW: assert property (up_cnt != 2'h3 |-> !amplifier_enable_out)
    else $error("amplifier enabled during boot");
  AST_LED_AMP: assert property (error_led |-> !amplifier_enable_out)
    else $error("error light on while amplifier enabled");
  AST_TRIP_STICKY: assert property (error_led && up_cnt == 2'h3 |=> error_led)
    else $error("trip cleared without reset");
  AST_FAULT_OFF: assert property (|amp_fault_in |-> ##[1:6] !amplifier_enable_out)
    else $error("fault did not disable amplifier");
  AST_STEP_WIDTH: assert property (step_rise |-> seq_pulse)
    else $error("step pulse width wrong");
  AST_STEP_RATE: assert property (step_rise |-> gap >= 5'd16)
    else $error("step pulses too close");
  AST_DAC_STEP: assert property (step_out |-> dac_word == 16'h0000)
    else $error("servo word nonzero in stepper mode");
endmodule

bind mai_axis mai_axis_sva #(.WDOG_CYC(WDOG_CYC)) u_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .amp_fault_in(amp_fault_in), .step_out(step_out), .dac_word(dac_word),
  .amplifier_enable_out(amplifier_enable_out), .error_led(error_led)
);

/* mai_enc_model.sv */
// encoder model driving phase and index pins
`timescale 1ns/1ps
module mai_enc_model (
  // clock
  input wire logic pclk,
  // encoder pins
  output logic phase_a,
  output logic phase_b,
  output logic index_out
);
  logic [1:0] st;
  initial begin
    st = 2'h0;
    phase_a = 1'b0;
    phase_b = 1'b0;
    index_out = 1'b0;
  end
  // gap of 4 cycles or more keeps counts below 15 M per second
  task automatic move(input int n, input logic [1:0] inc, input int gap);
    for (int j = 0; j < n; j++) begin
      repeat (gap) @(posedge pclk);
      st = st + inc;
      phase_a <= st[0] ^ st[1];
      phase_b <= st[1];
    end
  endtask
  task automatic pulses(input int n, input logic d);
    @(posedge pclk);
    phase_a <= 1'b0;
    phase_b <= d;
    for (int j = 0; j < n; j++) begin
      repeat (4) @(posedge pclk);
      phase_a <= 1'b1;
      repeat (4) @(posedge pclk);
      phase_a <= 1'b0;
    end
  endtask
  task automatic index_pulse;
    @(posedge pclk);
    index_out <= 1'b1;
    repeat (4) @(posedge pclk);
    index_out <= 1'b0;
  endtask
endmodule

/* tb_mai_axis.sv */
// self-checking testbench of the motor axis interface
`timescale 1ns/1ps
module tb_mai_axis;
  import mai_pkg::*;
  localparam int WD = 600;
  localparam logic [31:0] AMP = 32'h1 << MAI_CTRL_AMP_ON;
  localparam logic [31:0] LAT = 32'h1 << MAI_CTRL_LATCH_ARM;
  localparam logic [31:0] ZERO_IDX = 32'h1 << MAI_CTRL_INDEX_ZERO;
  logic pclk, presetn, psel, penable, pwrite, strap, pready, pslverr, err_q, step_out, dir_out;
  logic pwm_out, compare_out, amp, error_led, a, b, idx, step_q, dir, pwm_q;
  int pwm_gap = 0, pwm_per = 0;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q, e, v;
  logic [1:0] latch_in, step_gain, servo_gain, step_resolution;
  logic [3:0] amp_fault_in;
  logic [15:0] dac_word;
  logic [6:0] phase_current;
  logic [9:0] micro_position;
  int miscompares = 0, comparisons = 0, seed = 21753, n, m, i, k, p, s, pcount;
  mai_axis #(.WDOG_CYC(WD)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .encoder_phase_a(a),
    .encoder_phase_b(b), .encoder_index(idx), .latch_in(latch_in), .motor_off_strap(strap),
    .amp_fault_in(amp_fault_in), .step_out(step_out), .dir_out(dir_out), .dac_word(dac_word),
    .pwm_out(pwm_out), .compare_out(compare_out), .phase_current(phase_current), .step_gain(step_gain),
    .servo_gain(servo_gain), .step_resolution(step_resolution), .micro_position(micro_position),
    .amplifier_enable_out(amp), .error_led(error_led)
  );
  mai_enc_model enc (.pclk(pclk), .phase_a(a), .phase_b(b), .index_out(idx));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (step_out && !step_q) pcount++;
    step_q <= step_out;
    pwm_q <= pwm_out;
    pwm_gap <= (pwm_out && !pwm_q) ? 1 : pwm_gap + 1;
    if (pwm_out && !pwm_q) pwm_per <= pwm_gap;
  end
  // ****
  // tasks
  // ****
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    comparisons++;
    if (g !== x) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int t;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 16);
    q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (t >= 16) begin
      miscompares++;
      report_and_stop();
    end
  endtask
  task automatic kick;
    apb(1'b1, MAI_OFF_WDOG, {16'h0000, MAI_WDOG_KEY});
  endtask
  function automatic logic [9:0] next_micro(input logic [9:0] m0, input int st, input logic [1:0] r,
                                            input logic d);
    int u;
    u = (r == MAI_RES_SIXTEENTH) ? 16 : (256 >> r);
    return d ? m0 - 10'(st * u) : m0 + 10'(st * u);
  endfunction
  // ****
  // main sequence
  // ****
  initial begin
    {psel, penable, pwrite, paddr, pwdata, strap, latch_in, amp_fault_in, presetn} = '0;
    repeat (2) @(posedge pclk);
    chk({amp, error_led}, 32'h1);
    presetn <= 1'b1;
    apb(1'b0, 8'h3C, 32'h0);
    chk({err_q, q[30:0]}, 32'h80000000);
    kick();
    apb(1'b1, MAI_OFF_CTRL, AMP);
    repeat (3) @(posedge pclk);
    chk({amp, error_led}, 32'h2);
    $display("test reset done");
    n = 8 + ($random(seed) & 15);
    m = $random(seed) & 7;
    apb(1'b1, MAI_OFF_POSITION, 32'h0);
    enc.move(n, 2'h1, 4);
    enc.move(m, 2'h3, 9);
    enc.move(1, 2'h2, 6);
    repeat (6) @(posedge pclk);
    apb(1'b0, MAI_OFF_POSITION, 32'h0);
    chk(q, 32'(n - m));
    p = n - m + 2;
    apb(1'b1, MAI_OFF_COMPARE, 32'(p));
    apb(1'b1, MAI_OFF_CTRL, AMP | (32'h1 << MAI_CTRL_CMP_EN));
    enc.move(2, 2'h1, 5);
    repeat (6) @(posedge pclk);
    chk(compare_out, 32'h1);
    $display("test quadrature done");
    for (i = 0; i < 3; i++) begin
      kick();
      apb(1'b1, MAI_OFF_STATUS, 32'h4);
      apb(1'b1, MAI_OFF_CTRL, AMP | LAT | (32'(i) << MAI_CTRL_LSRC_LO) | ((i == 0) ? ZERO_IDX : 32'h0));
      enc.move(1, 2'h1, 4);
      p++;
      repeat (5) @(posedge pclk);
      latch_in <= 2'(i);
      if (i == 0) enc.index_pulse();
      else repeat (4) @(posedge pclk);
      latch_in <= 2'h0;
      repeat (5) @(posedge pclk);
      apb(1'b0, MAI_OFF_LATCH, 32'h0);
      chk(q, 32'(p));
      if (i == 0) p = 0;
    end
    $display("test latch done");
    kick();
    apb(1'b1, MAI_OFF_CTRL, AMP | (32'h1 << MAI_CTRL_PULSE_DIR));
    apb(1'b1, MAI_OFF_POSITION, 32'h0);
    enc.pulses(n, 1'b0);
    enc.pulses(m, 1'b1);
    repeat (6) @(posedge pclk);
    apb(1'b0, MAI_OFF_POSITION, 32'h0);
    chk(q, 32'(n - m));
    $display("test pulse direction done");
    apb(1'b1, MAI_OFF_STEP_PERIOD, 32'h0);
    for (i = 0; i < 5; i++) begin
      kick();
      dir = (i == 4);
      apb(1'b1, MAI_OFF_CTRL, AMP | (32'h1 << MAI_CTRL_STEPPER) | (32'(i & 3) << MAI_CTRL_RES_LO));
      apb(1'b0, MAI_OFF_MICRO, 32'h0);
      e = q;
      s = 1 + ($random(seed) & 3);
      pcount = 0;
      apb(1'b1, MAI_OFF_STEP_CMD, {15'h0, dir, 16'(s)});
      k = 0;
      do begin
        apb(1'b0, MAI_OFF_STEP_CMD, 32'h0);
        k++;
      end while (q[15:0] !== 16'h0 && k < 50);
      if (k >= 50) begin
        miscompares++;
        report_and_stop();
      end
      repeat (12) @(posedge pclk);
      apb(1'b0, MAI_OFF_MICRO, 32'h0);
      chk(q[9:0], next_micro(e[9:0], s, 2'(i & 3), dir));
      chk(micro_position, next_micro(e[9:0], s, 2'(i & 3), dir));
      chk(pcount, s);
      chk({dir_out, step_resolution}, {dir, 2'(i & 3)});
    end
    $display("test stepper done");
    kick();
    v = $random(seed);
    apb(1'b1, MAI_OFF_CTRL, AMP);
    apb(1'b1, MAI_OFF_DAC, {16'h0, v[31:16]});
    apb(1'b1, MAI_OFF_CURRENT, {20'h0, 2'h3, v[9:8], 1'b0, v[6:0]});
    repeat (3) @(posedge pclk);
    chk(dac_word, v[31:16]);
    chk(phase_current, v[6:0]);
    chk({step_gain, servo_gain}, {v[9:8], MAI_SERVO_GAIN_MAX});
    apb(1'b1, MAI_OFF_CTRL, AMP | (32'h1 << MAI_CTRL_IDLE_RED));
    repeat (3) @(posedge pclk);
    chk(phase_current, v[6:2]);
    apb(1'b1, MAI_OFF_DAC, 32'h00004000);
    repeat (8) begin
      kick();
      repeat (500) @(posedge pclk);
    end
    chk(pwm_per, MAI_PWM_CYC);
    $display("test current done");
    for (i = 0; i < 4; i++) begin
      kick();
      amp_fault_in <= 4'(1 << i);
      @(posedge pclk);
      amp_fault_in <= 4'h0;
      repeat (6) @(posedge pclk);
      chk(amp, 32'h0);
      apb(1'b0, MAI_OFF_STATUS, 32'h0);
      chk(q[7:4], 32'(1 << i));
      apb(1'b1, MAI_OFF_STATUS, 32'hF0);
      repeat (3) @(posedge pclk);
      chk(amp, 32'h1);
    end
    $display("test fault done");
    k = 0;
    while (amp === 1'b1 && k < WD + 100) begin
      @(posedge pclk);
      k++;
    end
    chk(k < WD + 100, 32'h1);
    chk(error_led, 32'h1);
    kick();
    repeat (4) @(posedge pclk);
    apb(1'b0, MAI_OFF_STATUS, 32'h0);
    chk({amp, q[0]}, 32'h1);
    $display("test watchdog done");
    strap <= 1'b1;
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    kick();
    apb(1'b1, MAI_OFF_CTRL, AMP);
    repeat (4) @(posedge pclk);
    apb(1'b0, MAI_OFF_STATUS, 32'h0);
    chk({amp, error_led, q[8]}, 32'h1);
    $display("test strap done");
    report_and_stop();
  end
endmodule
